/* File: rtl/dpc_pkg.sv */
// Package: register map, field positions, reset values and timing of the dynamics/power control bank
package dpc_pkg;

    // ************************************
    // Register offsets (byte address = 4 * index)
    // ************************************
    localparam logic [4:0] DPC_IDX_FAULT1 = 5'h08;
    localparam logic [4:0] DPC_IDX_POWER = 5'h09;
    localparam logic [4:0] DPC_IDX_ENABLE = 5'h0A;
    localparam logic [4:0] DPC_IDX_PEAK = 5'h0B;
    localparam logic [4:0] DPC_IDX_LIMCMP = 5'h0C;
    localparam logic [4:0] DPC_IDX_EXPGATE = 5'h0D;
    localparam logic [4:0] DPC_IDX_OUTLVL = 5'h0E;
    localparam logic [4:0] DPC_IDX_KNEE = 5'h0F;
    localparam logic [4:0] DPC_IDX_HOLD = 5'h10;
    localparam logic [4:0] DPC_IDX_POSTG = 5'h11;
    localparam logic [4:0] DPC_IDX_RMS = 5'h12;
    localparam logic [4:0] DPC_IDX_STATUS = 5'h13;
    localparam int DPC_NREG = 11;

    // ************************************
    // Reset values
    // ************************************
    localparam logic [7:0] DPC_RST_FAULT1 = 8'h0C;
    localparam logic [7:0] DPC_RST_POWER = 8'h99;
    localparam logic [7:0] DPC_RST_ENABLE = 8'h7C;
    localparam logic [7:0] DPC_RST_PEAK = 8'h5B;
    localparam logic [7:0] DPC_RST_LIMCMP = 8'h57;
    localparam logic [7:0] DPC_RST_EXPGATE = 8'h89;
    localparam logic [7:0] DPC_RST_OUTLVL = 8'h8C;
    localparam logic [7:0] DPC_RST_KNEE = 8'h77;
    localparam logic [7:0] DPC_RST_HOLD = 8'h26;
    localparam logic [7:0] DPC_RST_POSTG = 8'h1C;
    localparam logic [7:0] DPC_RST_RMS = 8'h07;

    // ************************************
    // Field positions
    // ************************************
    localparam int DPC_F_RECSEL_LSB = 0;
    localparam int DPC_F_ARTIME_LSB = 6;
    localparam int DPC_F_AMPLP = 4;
    localparam int DPC_F_CNVLP = 3;
    localparam int DPC_F_RPD = 2;
    localparam int DPC_F_LPD = 1;
    localparam int DPC_F_ASLEEP = 0;
    localparam int DPC_F_PREVOL = 6;
    localparam int DPC_F_LIM = 5;
    localparam int DPC_F_CMP = 4;
    localparam int DPC_F_EXP = 3;
    localparam int DPC_F_GATE = 2;
    localparam int DPC_F_MEN_LSB = 0;
    localparam int DPC_F_POSTG_LSB = 2;
    localparam logic [3:0] DPC_HOLD_MAX = 4'hC;

    // ************************************
    // Recovery policy codes
    // ************************************
    localparam logic [1:0] DPC_RECSEL_BOTH = 2'h0;
    localparam logic [1:0] DPC_RECSEL_OT = 2'h1;
    localparam logic [1:0] DPC_RECSEL_OC = 2'h2;
    localparam logic [1:0] DPC_RECSEL_NONE = 2'h3;

    // ************************************
    // Timing
    // ************************************
    localparam int DPC_CLK_HZ = 50000000;
    localparam int DPC_RECOV_BASE_MS = 10;
    localparam int DPC_RECOV_BASE_CYC = DPC_CLK_HZ / 1000 * DPC_RECOV_BASE_MS;
    localparam int DPC_ZERO_RUN = 2048;
    localparam int DPC_THR_OFFSET_DB = 6;

    // ************************************
    // Carriers
    // ************************************
    typedef struct packed {
        logic output_stage_low_power;
        logic converter_low_power;
        logic right_channel_off;
        logic left_channel_off;
        logic asleep;
        logic left_dyn_on;
        logic right_dyn_on;
        logic limiter_on;
        logic compressor_on;
        logic expander_on;
        logic gate_on;
        logic dynamics_before_volume;
        logic recovery_pulse;
    } dpc_ctrl_t;

    typedef struct packed {
        logic [7:0] limiter_threshold_db;
        logic [7:0] compressor_threshold_db;
        logic [7:0] expander_threshold_db;
        logic [7:0] gate_threshold_db;
        logic [7:0] max_output_db;
        logic [7:0] min_output_db;
        logic [7:0] post_gain_db;
        logic [3:0] peak_attack_time;
        logic [3:0] peak_release_time;
        logic [3:0] knee_attack_time;
        logic [3:0] knee_decay_time;
        logic [3:0] normal_hold_time;
        logic [3:0] gate_hold_time;
        logic [3:0] rms_average_time;
    } dpc_dyn_t;

endpackage : dpc_pkg

/* File: rtl/dpc_regs.sv */
// Module: dynamics and power control register bank with Wishbone slave
// Overview of operation
// - Recovery policy: both, overtemp, overcurrent, none
// - Recovery delay 10, 20, 40, 80 ms
// - Bit 4 selects output stage low power
// - Bit 3 halves converter processing rate
// - Bits 2/1 power down right/left independently
// - Auto sleep after 2048 zero samples
// - Bit 6 puts dynamics before volume
// - After volume, thresholds applied 6 dB higher
// - Master enable selects left, right, both
// - Per-function enables; software programs thresholds
// - Peak attack time code, 0 to 1.536 s
// - Peak release time code, 0 to 24.576 s
// - Limiter threshold 0 to -22 dB
// - Compressor threshold -4 to -34 dB
// - Expander threshold -36 to -81 dB
// - Gate threshold -51 to -96 dB
// - Minimum output level from -51 dB, 3 dB steps
// - Knee attack and decay time codes
// - Normal hold time; codes above 1100 reserved
// - Gate hold time, same encoding
// - Post gain +21 dB down, 0 dB at 0111
// - RMS averaging time, default code 0111
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dpc_regs
(
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Fault and sample inputs
    input wire logic fault_overtemp,
    input wire logic fault_overcurrent,
    input wire logic sample_valid,
    input wire logic sample_zero,
    // Control outputs
    output dpc_pkg::dpc_ctrl_t ctrl,
    output dpc_pkg::dpc_dyn_t dyn
);

    // ************************************
    // State
    // ************************************
    typedef enum logic [2:0]
    {
        DPC_S_RUN = 3'b001,
        DPC_S_WAIT = 3'b010,
        DPC_S_HELD = 3'b100
    } dpc_rec_t;

    typedef struct packed {
        logic [dpc_pkg::DPC_NREG-1:0][7:0] regs;
        logic ack;
        logic err;
        logic [31:0] rdata;
        dpc_rec_t rec;
        logic [31:0] wait_cnt;
        logic rec_pulse;
        logic [11:0] zero_cnt;
        logic asleep;
        logic hold_bad;
    } dpc_state_t;

    dpc_state_t s_q;
    dpc_state_t s_d;

    // ************************************
    // Decode helpers
    // ************************************
    logic [4:0] idx;
    logic hit;
    logic [3:0] slot;
    logic req;
    logic [1:0] rec_sel;
    logic [1:0] artime;
    logic fault_any;
    logic fault_auto;
    logic [31:0] delay_cyc;

    assign idx = wb_adr_i[6:2];
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack & ~s_q.err;
    assign hit = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[7] == 1'b0)
        && (idx >= dpc_pkg::DPC_IDX_FAULT1) && (idx <= dpc_pkg::DPC_IDX_STATUS);
    assign slot = 4'(idx - dpc_pkg::DPC_IDX_FAULT1);

    // ************************************
    // Register views and status word
    // ************************************
    logic [7:0] r_power;
    logic [7:0] r_enable;
    logic [7:0] r_hold;
    logic is_status;
    logic wr_hit;
    logic [31:0] status_word;

    assign r_power = s_q.regs[dpc_pkg::DPC_IDX_POWER - dpc_pkg::DPC_IDX_FAULT1];
    assign r_enable = s_q.regs[dpc_pkg::DPC_IDX_ENABLE - dpc_pkg::DPC_IDX_FAULT1];
    assign r_hold = s_q.regs[dpc_pkg::DPC_IDX_HOLD - dpc_pkg::DPC_IDX_FAULT1];
    assign is_status = (idx == dpc_pkg::DPC_IDX_STATUS);
    // Writes with an empty low lane are acknowledged and dropped
    assign wr_hit = wb_we_i & wb_sel_i[0];
    // Recovery wait, asleep, reserved hold code
    assign status_word = {29'h0, s_q.hold_bad, s_q.asleep, s_q.rec == DPC_S_WAIT};

    assign rec_sel = s_q.regs[0][dpc_pkg::DPC_F_RECSEL_LSB +: 2];
    assign artime = r_power[dpc_pkg::DPC_F_ARTIME_LSB +: 2];
    assign fault_any = fault_overtemp | fault_overcurrent;

    // Faults eligible for automatic recovery under the policy
    always_comb
    begin
        case (rec_sel)
            dpc_pkg::DPC_RECSEL_BOTH: fault_auto = fault_any;
            dpc_pkg::DPC_RECSEL_OT: fault_auto = fault_overtemp & ~fault_overcurrent;
            dpc_pkg::DPC_RECSEL_OC: fault_auto = fault_overcurrent & ~fault_overtemp;
            default: fault_auto = 1'b0;
        endcase
    end

    // 10 ms doubled per code step
    assign delay_cyc = 32'(dpc_pkg::DPC_RECOV_BASE_CYC) << artime;

    function automatic logic [7:0] dpc_reset_val(input int i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            0: v = dpc_pkg::DPC_RST_FAULT1;
            1: v = dpc_pkg::DPC_RST_POWER;
            2: v = dpc_pkg::DPC_RST_ENABLE;
            3: v = dpc_pkg::DPC_RST_PEAK;
            4: v = dpc_pkg::DPC_RST_LIMCMP;
            5: v = dpc_pkg::DPC_RST_EXPGATE;
            6: v = dpc_pkg::DPC_RST_OUTLVL;
            7: v = dpc_pkg::DPC_RST_KNEE;
            8: v = dpc_pkg::DPC_RST_HOLD;
            9: v = dpc_pkg::DPC_RST_POSTG;
            10: v = dpc_pkg::DPC_RST_RMS;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ************************************
    // Next state
    // ************************************
    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.rec_pulse = 1'b0;

        // Bus access, one-cycle ack
        if (req)
        begin
            if (hit)
            begin
                s_d.ack = 1'b1;
                if (is_status)
                begin
                    s_d.rdata = status_word;
                end
                else
                begin
                    s_d.rdata = {24'h0, s_q.regs[slot]};
                    // Reserved bits stored and read back
                    if (wr_hit)
                    begin
                        s_d.regs[slot] = wb_dat_i[7:0];
                    end
                end
            end
            else
            begin
                s_d.err = 1'b1;
                s_d.rdata = 32'h0;
            end
        end

        // Automatic recovery sequencer
        case (s_q.rec)
            DPC_S_RUN:
            begin
                if (fault_auto)
                begin
                    s_d.rec = DPC_S_WAIT;
                    s_d.wait_cnt = 32'h0;
                end
            end
            DPC_S_WAIT:
            begin
                if (rec_sel == dpc_pkg::DPC_RECSEL_NONE)
                begin
                    s_d.rec = DPC_S_RUN;
                end
                else if (s_q.wait_cnt + 32'h1 >= delay_cyc)
                begin
                    s_d.rec = DPC_S_HELD;
                    s_d.rec_pulse = 1'b1;
                end
                else
                begin
                    s_d.wait_cnt = s_q.wait_cnt + 32'h1;
                end
            end
            DPC_S_HELD:
            begin
                if (!fault_any)
                begin
                    s_d.rec = DPC_S_RUN;
                end
                else if (fault_auto)
                begin
                    s_d.rec = DPC_S_WAIT;
                    s_d.wait_cnt = 32'h0;
                end
            end
            default: s_d.rec = DPC_S_RUN;
        endcase

        // Zero-sample run detector for auto sleep
        if (!r_power[dpc_pkg::DPC_F_ASLEEP])
        begin
            s_d.zero_cnt = 12'h000;
            s_d.asleep = 1'b0;
        end
        else if (sample_valid)
        begin
            if (!sample_zero)
            begin
                s_d.zero_cnt = 12'h000;
                s_d.asleep = 1'b0;
            end
            else if (s_q.zero_cnt + 12'h001 >= 12'(dpc_pkg::DPC_ZERO_RUN))
            begin
                s_d.asleep = 1'b1;
                s_d.zero_cnt = 12'(dpc_pkg::DPC_ZERO_RUN);
            end
            else
            begin
                s_d.zero_cnt = s_q.zero_cnt + 12'h001;
            end
        end

        // Reserved hold time codes flagged
        s_d.hold_bad = (r_hold[7:4] > dpc_pkg::DPC_HOLD_MAX)
            || (r_hold[3:0] > dpc_pkg::DPC_HOLD_MAX);
    end

    // ************************************
    // Registers
    // ************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < dpc_pkg::DPC_NREG; i++)
            begin
                s_q.regs[i] <= dpc_reset_val(i);
            end
            s_q.ack <= 1'b0;
            s_q.err <= 1'b0;
            s_q.rdata <= 32'h0;
            s_q.rec <= DPC_S_RUN;
            s_q.wait_cnt <= 32'h0;
            s_q.rec_pulse <= 1'b0;
            s_q.zero_cnt <= 12'h000;
            s_q.asleep <= 1'b0;
            s_q.hold_bad <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_err_o = s_q.err;
    assign wb_dat_o = s_q.rdata;

    // ************************************
    // Threshold decoding (magnitudes in dB below full scale)
    // ************************************
    logic [7:0] off_db;
    logic [3:0] lt;
    logic [3:0] ct;
    logic [3:0] et;
    logic [3:0] nt;
    logic [3:0] smax;
    logic [3:0] smin;
    logic [3:0] pg;

    assign lt = s_q.regs[4][7:4];
    assign ct = s_q.regs[4][3:0];
    assign et = s_q.regs[5][7:4];
    assign nt = s_q.regs[5][3:0];
    assign smax = s_q.regs[6][7:4];
    assign smin = s_q.regs[6][3:0];
    assign pg = s_q.regs[9][dpc_pkg::DPC_F_POSTG_LSB +: 4];

    // Thresholds raised after volume: attenuation shrinks by 6 dB
    assign off_db = s_q.regs[2][dpc_pkg::DPC_F_PREVOL] ? 8'h00
        : 8'(dpc_pkg::DPC_THR_OFFSET_DB);

    // Limiter-style scale: 1 dB steps to 8, then 2 dB steps
    function automatic logic [7:0] dpc_lim_db(input logic [3:0] c);
        logic [7:0] v;
        v = (c <= 4'h8) ? {4'h0, c} : 8'({4'h0, c} * 8'h02 - 8'h08);
        return v;
    endfunction

    // Signed subtraction, negative result means above full scale
    function automatic logic [7:0] dpc_sub(input logic [7:0] a, input logic [7:0] b);
        return 8'(a - b);
    endfunction

    always_comb
    begin
        dyn.limiter_threshold_db = dpc_sub(dpc_lim_db(lt), off_db);
        dyn.compressor_threshold_db = dpc_sub(8'(8'h04 + {4'h0, ct} * 8'h02), off_db);
        dyn.expander_threshold_db = dpc_sub(8'(8'h24 + {4'h0, et} * 8'h03), off_db);
        dyn.gate_threshold_db = dpc_sub(8'(8'h33 + {4'h0, nt} * 8'h03), off_db);
        dyn.max_output_db = dpc_sub(dpc_lim_db(smax), off_db);
        dyn.min_output_db = dpc_sub(8'(8'h33 + {4'h0, smin} * 8'h03), off_db);
        // Signed gain: +21 dB at 0, 3 dB per code down
        dyn.post_gain_db = 8'(8'h15 - {4'h0, pg} * 8'h03);
        dyn.peak_attack_time = s_q.regs[3][7:4];
        dyn.peak_release_time = s_q.regs[3][3:0];
        dyn.knee_attack_time = s_q.regs[7][7:4];
        dyn.knee_decay_time = s_q.regs[7][3:0];
        dyn.normal_hold_time = s_q.regs[8][7:4];
        dyn.gate_hold_time = s_q.regs[8][3:0];
        dyn.rms_average_time = s_q.regs[10][3:0];
    end

    // ************************************
    // Control outputs
    // ************************************
    logic [1:0] men;
    assign men = r_enable[dpc_pkg::DPC_F_MEN_LSB +: 2];

    always_comb
    begin
        ctrl.output_stage_low_power = r_power[dpc_pkg::DPC_F_AMPLP];
        ctrl.converter_low_power = r_power[dpc_pkg::DPC_F_CNVLP];
        ctrl.right_channel_off = r_power[dpc_pkg::DPC_F_RPD];
        ctrl.left_channel_off = r_power[dpc_pkg::DPC_F_LPD];
        ctrl.asleep = s_q.asleep;
        ctrl.left_dyn_on = men[0];
        ctrl.right_dyn_on = men[1];
        ctrl.limiter_on = (men != 2'h0) & r_enable[dpc_pkg::DPC_F_LIM];
        ctrl.compressor_on = (men != 2'h0) & r_enable[dpc_pkg::DPC_F_CMP];
        ctrl.expander_on = (men != 2'h0) & r_enable[dpc_pkg::DPC_F_EXP];
        ctrl.gate_on = (men != 2'h0) & r_enable[dpc_pkg::DPC_F_GATE];
        ctrl.dynamics_before_volume = r_enable[dpc_pkg::DPC_F_PREVOL];
        ctrl.recovery_pulse = s_q.rec_pulse;
    end

endmodule // dpc_regs

`default_nettype wire

/* File: verification/dpc_regs_assertions.sv */
// Checker: bus timing, control decode and auto sleep of the dpc bank
`timescale 1ns/1ps
`default_nettype none
module dpc_regs_checker
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic fault_overtemp,
    input wire logic fault_overcurrent,
    input wire logic sample_valid,
    input wire logic sample_zero,
    input wire dpc_pkg::dpc_ctrl_t ctrl,
    input wire dpc_pkg::dpc_dyn_t dyn
);
    logic bad_adr;
    logic wr_ack;
    logic en_q;
    logic [11:0] zc_q;
    assign bad_adr = (wb_adr_i[1:0] != 2'h0) || wb_adr_i[7] || (wb_adr_i[6:2] < 5'h08)
        || (wb_adr_i[6:2] > 5'h13);
    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
    // Shadow of the sleep enable and of the zero-sample run
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_q <= 1'b1;
            zc_q <= 12'h000;
        end
        else
        begin
            if (wr_ack && wb_adr_i == 8'h24)
                en_q <= wb_dat_i[0];
            if (sample_valid && !sample_zero)
                zc_q <= 12'h000;
            else if (sample_valid && zc_q != 12'h800)
                zc_q <= zc_q + 12'h001;
        end
    end
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o ^ wb_err_o) else $error("request not answered in one cycle");
    a_ack_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("answer longer than one cycle");
    a_err_unmapped: assert property (wb_cyc_i && wb_stb_i && (wb_ack_o || wb_err_o)
        |-> wb_err_o == bad_adr) else $error("error flag does not match address");
    a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_power_decode: assert property (wr_ack && wb_adr_i == 8'h24 |->
        {ctrl.output_stage_low_power, ctrl.converter_low_power, ctrl.right_channel_off,
        ctrl.left_channel_off} == wb_dat_i[4:1]) else $error("power controls wrong");
    a_enable_decode: assert property (wr_ack && wb_adr_i == 8'h28 |->
        ctrl.dynamics_before_volume == wb_dat_i[6] && ctrl.left_dyn_on == wb_dat_i[0]
        && ctrl.limiter_on == (wb_dat_i[5] && |wb_dat_i[1:0]))
        else $error("dynamics enables wrong");
    a_gate_master: assert property (ctrl.limiter_on || ctrl.compressor_on
        || ctrl.expander_on || ctrl.gate_on |-> ctrl.left_dyn_on || ctrl.right_dyn_on)
        else $error("function on without master enable");
    a_sleep_entry: assert property (sample_valid && sample_zero && zc_q == 12'h7FF
        && en_q |=> ctrl.asleep) else $error("no sleep after zero run");
    a_sleep_off: assert property (!en_q |=> !ctrl.asleep)
        else $error("asleep while disabled");
    a_sleep_cause: assert property ($rose(ctrl.asleep) |->
        $past(sample_valid && sample_zero)) else $error("sleep without zero sample");
    a_recov_pulse: assert property (ctrl.recovery_pulse |=> !ctrl.recovery_pulse)
        else $error("recovery pulse too long");
    c_write: cover property (wr_ack);
    c_refused: cover property (wb_err_o);
    c_sleep: cover property ($rose(ctrl.asleep));
endmodule // dpc_regs_checker
bind dpc_regs dpc_regs_checker u_dpc_regs_checker (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .fault_overtemp(fault_overtemp),
    .fault_overcurrent(fault_overcurrent), .sample_valid(sample_valid),
    .sample_zero(sample_zero), .ctrl(ctrl), .dyn(dyn));
`default_nettype wire

/* File: verification/dpc_tb.sv */
// Testbench: register access, decode, recovery policy and auto sleep
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic fault_overtemp = 1'b0;
    logic fault_overcurrent = 1'b0;
    logic sample_valid = 1'b0;
    logic sample_zero = 1'b0;
    dpc_pkg::dpc_ctrl_t ctrl;
    dpc_pkg::dpc_dyn_t dyn;
    int checks = 0;
    int bad_count = 0;
    logic [7:0] sh [10] = '{8'h99, 8'h7C, 8'h5B, 8'h57, 8'h89, 8'h8C, 8'h77, 8'h26, 8'h1C, 8'h07};
    logic [7:0] holes [4] = '{8'h1C, 8'h50, 8'h25, 8'hA4};
    always #10 sys_clk = ~sys_clk;
    dpc_regs u_dpc_regs (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .fault_overtemp(fault_overtemp), .fault_overcurrent(fault_overcurrent),
        .sample_valid(sample_valid), .sample_zero(sample_zero), .ctrl(ctrl), .dyn(dyn));
    // ****
    // Tasks
    // ****
    task automatic close_out();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] s, output logic [31:0] q, output logic e);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
                break;
        end
        if (n == 20)
        begin
            bad_count++;
            close_out();
        end
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, 4'hF, q, e);
        cmp(32'(e), 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 8'h00, 4'hF, q, e);
        cmp({q[31:8], q[7:0] & m}, {24'h000000, x & m});
    endtask
    task automatic samp(input int n, input logic z);
        repeat (n)
        begin
            @(posedge sys_clk);
            sample_valid <= 1'b1;
            sample_zero <= z;
            @(posedge sys_clk);
            sample_valid <= 1'b0;
        end
        @(negedge sys_clk);
    endtask
    function automatic logic [7:0] lim_db(input logic [3:0] c);
        return (c <= 4'h8) ? {4'h0, c} : 8'(2 * c - 8);
    endfunction
    task automatic cfg();
        logic [7:0] e;
        logic [7:0] off;
        e = sh[1];
        off = e[6] ? 8'h00 : 8'h06;
        cmp(32'({ctrl.output_stage_low_power, ctrl.converter_low_power, ctrl.right_channel_off,
            ctrl.left_channel_off}), 32'(sh[0][4:1]));
        cmp(32'({ctrl.left_dyn_on, ctrl.right_dyn_on, ctrl.dynamics_before_volume,
            ctrl.limiter_on, ctrl.compressor_on, ctrl.expander_on, ctrl.gate_on}),
            32'({e[0], e[1], e[6], e[5:2] & {4{|e[1:0]}}}));
        cmp({dyn.limiter_threshold_db, dyn.compressor_threshold_db, dyn.expander_threshold_db,
            dyn.gate_threshold_db}, {lim_db(sh[3][7:4]) - off, 8'(4 + 2 * sh[3][3:0]) - off,
            8'(36 + 3 * sh[4][7:4]) - off, 8'(51 + 3 * sh[4][3:0]) - off});
        cmp(32'({dyn.max_output_db, dyn.min_output_db}),
            32'({lim_db(sh[5][7:4]) - off, 8'(51 + 3 * sh[5][3:0]) - off}));
        cmp(32'(dyn.post_gain_db), 32'(8'(21 - 3 * sh[8][5:2])));
        cmp(32'({dyn.peak_attack_time, dyn.peak_release_time, dyn.knee_attack_time,
            dyn.knee_decay_time, dyn.normal_hold_time, dyn.gate_hold_time,
            dyn.rms_average_time}), 32'({sh[2], sh[6], sh[7], sh[9][3:0]}));
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        logic [31:0] q;
        logic e;
        logic [3:0] c;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h20, 8'h0C, 8'hFF);
        for (int i = 0; i < 10; i++)
            rd(8'(8'h24 + 4 * i), sh[i], 8'hFF);
        cfg();
        for (int k = 0; k < 16; k++)
        begin
            c = 4'(k);
            for (int i = 0; i < 10; i++)
            begin
                sh[i] = {c, c};
                wr(8'(8'h24 + 4 * i), sh[i]);
            end
            for (int i = 0; i < 10; i++)
                rd(8'(8'h24 + 4 * i), sh[i], 8'hFF);
            rd(8'h4C, {5'h00, c > 4'hC, 2'h0}, 8'h04);
            cfg();
        end
        bus(1'b1, 8'h24, 8'h00, 4'hE, q, e);
        rd(8'h24, sh[0], 8'hFF);
        foreach (holes[j])
        begin
            bus(1'b1, holes[j], 8'h00, 4'hF, q, e);
            cmp(32'(e), 32'h1);
        end
        rd(8'h24, sh[0], 8'hFF);
        for (int p = 0; p < 4; p++)
            for (int f = 0; f < 2; f++)
            begin
                wr(8'h20, 8'(p));
                fault_overtemp <= (f == 0);
                fault_overcurrent <= (f == 1);
                repeat (2) @(posedge sys_clk);
                rd(8'h4C, 8'((p == 0) || (p == 1 && f == 0) || (p == 2 && f == 1)), 8'h01);
                fault_overtemp <= 1'b0;
                fault_overcurrent <= 1'b0;
                wr(8'h20, 8'h03);
                rd(8'h4C, 8'h00, 8'h03);
                cmp(32'(ctrl.recovery_pulse), 32'h0);
            end
        wr(8'h24, 8'h01);
        samp(1, 1'b0);
        samp(2047, 1'b1);
        cmp(32'(ctrl.asleep), 32'h0);
        samp(1, 1'b1);
        cmp(32'(ctrl.asleep), 32'h1);
        rd(8'h4C, 8'h02, 8'h02);
        samp(1, 1'b0);
        cmp(32'(ctrl.asleep), 32'h0);
        wr(8'h24, 8'h00);
        samp(2048, 1'b1);
        cmp(32'(ctrl.asleep), 32'h0);
        close_out();
    end
endmodule // tb
`default_nettype wire
